// >>> inc/watchdog_defs.svh
// What this block does
// - At terminal count the watchdog gives its chosen response, reset or interrupt.
// - Software selects the time-out response: forced reset or interrupt request.
// - The counter advances on its own slow oscillator tick, not the system clock.
// - Only two operating states exist: off and on.
// - Once on, it counts without pause; software must refresh it to avoid time-out.
// - A refresh instruction or the always-on option bit turns the watchdog on.
// - With the always-on option set, counting starts right after reset.
// - A 24-bit reloadable down counter, reload held in three 8-bit registers.
// - Reload value is upper, high and low byte, upper byte most significant.
// - Nominal time-out in milliseconds is the reload value divided by ten.
// - Refresh is ignored once the count has reached two.
`ifndef WATCHDOG_DEFS_SVH
`define WATCHDOG_DEFS_SVH

`define WD_CLK_FREQ_HZ 50000000
`define WD_RC_FREQ_HZ 10000
`define WD_TICK_DIV (`WD_CLK_FREQ_HZ / `WD_RC_FREQ_HZ)

`define WD_ADDR_W 8
`define WD_OFF_CTRL 8'h00
`define WD_OFF_RELOAD_UPPER 8'h04
`define WD_OFF_RELOAD_HIGH 8'h08
`define WD_OFF_RELOAD_LOW 8'h0c
`define WD_OFF_REFRESH 8'h10
`define WD_OFF_STATUS 8'h14
`define WD_OFF_INT_STAT 8'h18
`define WD_OFF_INT_MASK 8'h1c
`define WD_OFF_COUNT 8'h20

`define WD_CTRL_RESP_BIT 0
`define WD_STAT_ON_BIT 0
`define WD_STAT_LOCK_BIT 1
`define WD_STAT_AO_BIT 2
`define WD_INT_TIMEOUT_BIT 0
`define WD_INT_REFUSED_BIT 1
`define WD_INT_W 2

`define WD_RST_UPPER 8'hff
`define WD_RST_HIGH 8'hff
`define WD_RST_LOW 8'hff
`define WD_RST_CTRL 1'b0
`define WD_RST_MASK 2'h0

`define WD_LOCK_COUNT 24'h000002
`define WD_MIN_RELOAD 24'h000004
`define WD_LAST_COUNT 24'h000001

`define WD_RESP_OKAY 2'h0
`define WD_RESP_SLVERR 2'h2

`endif

// >>> inc/watchdog_pkg.sv
package watchdog_pkg;
  typedef enum logic {ST_OFF, ST_ON} wd_state_t;
  typedef logic [23:0] wd_count_t;
endpackage

// >>> hdl/wd_sync3.sv
`timescale 1ns/1ps
module wd_sync3 (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q_o <= 1'b0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // A level counts only once two settled stages agree
      if (s2_r == s3_r) begin
        q_o <= s3_r;
      end
    end
  end
endmodule // wd_sync3

// >>> hdl/wd_tick_gen.sv
`timescale 1ns/1ps
module wd_tick_gen #(
  parameter int unsigned DIV = 5000
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  output logic tick_o
);
  logic [31:0] cnt_r;
  wire last_w = (cnt_r == 32'(DIV - 1));

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= 32'h0;
      tick_o <= 1'b0;
    end else begin
      cnt_r <= last_w ? 32'h0 : cnt_r + 32'h1;
      tick_o <= last_w;
    end
  end
endmodule // wd_tick_gen

// >>> hdl/watchdog_timeout_counter.sv
`timescale 1ns/1ps
`include "watchdog_defs.svh"
module watchdog_timeout_counter #(
  parameter int unsigned TICK_DIV = `WD_TICK_DIV
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic watchdog_always_on_option_i,
  input wire logic [`WD_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [`WD_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic wd_reset_req_o,
  output logic irq_o
);

  // Write and read channel holding registers
  logic aw_held_r;
  logic [`WD_ADDR_W-1:0] aw_addr_r;
  logic w_held_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // Software visible state
  logic resp_irq_r;
  logic [7:0] reload_upper_byte_r;
  logic [7:0] reload_high_byte_r;
  logic [7:0] reload_low_byte_r;
  logic [`WD_INT_W-1:0] int_stat_r;
  logic [`WD_INT_W-1:0] int_stat_nxt;
  logic [`WD_INT_W-1:0] int_mask_r;

  // Counter state
  watchdog_pkg::wd_state_t state_r;
  watchdog_pkg::wd_state_t state_nxt;
  watchdog_pkg::wd_count_t count_r;
  watchdog_pkg::wd_count_t count_nxt;
  logic timeout;
  logic irq_r;
  logic wd_reset_r;

  logic rc_tick;
  logic always_on;

  // Slow oscillator stand-in: one enable pulse per oscillator period
  wd_tick_gen #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .tick_o(rc_tick)
  );

  // Option bit comes from outside this clock domain
  wd_sync3 u_ao_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i(watchdog_always_on_option_i),
    .q_o(always_on)
  );

  // Write path decode
  wire wr_go = aw_held_r & w_held_r & ~bvalid_r;
  wire wr_lane0 = w_strb_r[0];
  wire wr_ctrl = wr_go & wr_lane0 & (aw_addr_r == `WD_OFF_CTRL);
  wire wr_upper = wr_go & wr_lane0 & (aw_addr_r == `WD_OFF_RELOAD_UPPER);
  wire wr_high = wr_go & wr_lane0 & (aw_addr_r == `WD_OFF_RELOAD_HIGH);
  wire wr_low = wr_go & wr_lane0 & (aw_addr_r == `WD_OFF_RELOAD_LOW);
  wire wr_refresh = wr_go & (aw_addr_r == `WD_OFF_REFRESH);
  wire wr_int_stat = wr_go & wr_lane0 & (aw_addr_r == `WD_OFF_INT_STAT);
  wire wr_int_mask = wr_go & wr_lane0 & (aw_addr_r == `WD_OFF_INT_MASK);
  wire wr_mapped = (aw_addr_r == `WD_OFF_CTRL) |
                   (aw_addr_r == `WD_OFF_RELOAD_UPPER) |
                   (aw_addr_r == `WD_OFF_RELOAD_HIGH) |
                   (aw_addr_r == `WD_OFF_RELOAD_LOW) |
                   (aw_addr_r == `WD_OFF_REFRESH) |
                   (aw_addr_r == `WD_OFF_STATUS) |
                   (aw_addr_r == `WD_OFF_INT_STAT) |
                   (aw_addr_r == `WD_OFF_INT_MASK) |
                   (aw_addr_r == `WD_OFF_COUNT);

  assign s_axi_awready_o = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready_o = ~w_held_r & ~bvalid_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;

  // Reload value, upper byte most significant
  wire [23:0] reload_value = {reload_upper_byte_r, reload_high_byte_r,
                              reload_low_byte_r};

  // Refresh is locked out near the end so a late refresh cannot save a stuck program
  wire refresh_locked = (state_r == watchdog_pkg::ST_ON) &
                        (count_r <= `WD_LOCK_COUNT);
  wire refresh_ok = wr_refresh & ~refresh_locked;
  wire refresh_refused = wr_refresh & refresh_locked;

  // Counter next state
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    timeout = 1'b0;
    unique case (state_r)
      watchdog_pkg::ST_OFF: begin
        if (wr_refresh | always_on) begin
          state_nxt = watchdog_pkg::ST_ON;
          count_nxt = reload_value;
        end
      end
      watchdog_pkg::ST_ON: begin
        if (refresh_ok) begin
          count_nxt = reload_value;
        end else if (rc_tick) begin
          if (count_r <= `WD_LAST_COUNT) begin
            // Terminal count: fire and keep counting from the reload value
            timeout = 1'b1;
            count_nxt = reload_value;
          end else begin
            count_nxt = count_r - 24'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= watchdog_pkg::ST_OFF;
      count_r <= {`WD_RST_UPPER, `WD_RST_HIGH, `WD_RST_LOW};
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
    end
  end

  // Response selection
  wire timeout_irq = timeout & resp_irq_r;
  wire timeout_rst = timeout & ~resp_irq_r;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wd_reset_r <= 1'b0;
    end else begin
      wd_reset_r <= timeout_rst;
    end
  end
  assign wd_reset_req_o = wd_reset_r;

  // Sticky events; a new event wins over a same-cycle write-one-to-clear
  wire [`WD_INT_W-1:0] int_set = {refresh_refused, timeout_irq};
  wire [`WD_INT_W-1:0] int_clr = wr_int_stat ? w_data_r[`WD_INT_W-1:0] : '0;
  assign int_stat_nxt = (int_stat_r & ~int_clr) | int_set;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      int_stat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      int_stat_r <= int_stat_nxt;
      irq_r <= |(int_stat_nxt & int_mask_r);
    end
  end
  assign irq_o = irq_r;

  // Software registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      resp_irq_r <= `WD_RST_CTRL;
      reload_upper_byte_r <= `WD_RST_UPPER;
      reload_high_byte_r <= `WD_RST_HIGH;
      reload_low_byte_r <= `WD_RST_LOW;
      int_mask_r <= `WD_RST_MASK;
    end else begin
      if (wr_ctrl) begin
        resp_irq_r <= w_data_r[`WD_CTRL_RESP_BIT];
      end
      // Values below the minimum reload are software's to avoid, stored as given
      if (wr_upper) begin
        reload_upper_byte_r <= w_data_r[7:0];
      end
      if (wr_high) begin
        reload_high_byte_r <= w_data_r[7:0];
      end
      if (wr_low) begin
        reload_low_byte_r <= w_data_r[7:0];
      end
      if (wr_int_mask) begin
        int_mask_r <= w_data_r[`WD_INT_W-1:0];
      end
    end
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid_i & s_axi_awready_o) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr_i;
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid_i & s_axi_wready_o) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata_i;
      w_strb_r <= s_axi_wstrb_i;
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= `WD_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? `WD_RESP_OKAY : `WD_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read path
  wire [31:0] status_word = {29'h0, always_on, refresh_locked,
                             state_r == watchdog_pkg::ST_ON};
  wire rd_ctrl = (s_axi_araddr_i == `WD_OFF_CTRL);
  wire rd_upper = (s_axi_araddr_i == `WD_OFF_RELOAD_UPPER);
  wire rd_high = (s_axi_araddr_i == `WD_OFF_RELOAD_HIGH);
  wire rd_low = (s_axi_araddr_i == `WD_OFF_RELOAD_LOW);
  wire rd_refresh = (s_axi_araddr_i == `WD_OFF_REFRESH);
  wire rd_status = (s_axi_araddr_i == `WD_OFF_STATUS);
  wire rd_int_stat = (s_axi_araddr_i == `WD_OFF_INT_STAT);
  wire rd_int_mask = (s_axi_araddr_i == `WD_OFF_INT_MASK);
  wire rd_count = (s_axi_araddr_i == `WD_OFF_COUNT);
  wire rd_mapped = rd_ctrl | rd_upper | rd_high | rd_low | rd_refresh |
                   rd_status | rd_int_stat | rd_int_mask | rd_count;
  // Refresh register reads as zero; it only has a write effect
  wire [31:0] rd_word =
    ({32{rd_ctrl}} & {31'h0, resp_irq_r}) |
    ({32{rd_upper}} & {24'h0, reload_upper_byte_r}) |
    ({32{rd_high}} & {24'h0, reload_high_byte_r}) |
    ({32{rd_low}} & {24'h0, reload_low_byte_r}) |
    ({32{rd_status}} & status_word) |
    ({32{rd_int_stat}} & {30'h0, int_stat_r}) |
    ({32{rd_int_mask}} & {30'h0, int_mask_r}) |
    ({32{rd_count}} & {8'h0, count_r});

  assign s_axi_arready_o = ~rvalid_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= `WD_RESP_OKAY;
    end else if (s_axi_arvalid_i & s_axi_arready_o) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_mapped ? `WD_RESP_OKAY : `WD_RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule // watchdog_timeout_counter

// >>> testbench/watchdog_timeout_counter_checker.sv
`timescale 1ns/1ps
`include "watchdog_defs.svh"
module watchdog_timeout_counter_checker #(
  parameter int unsigned TICK_DIV = 4
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [`WD_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic wd_reset_req_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [`WD_ADDR_W-1:0] ar_r;
  logic [15:0] gap_r;
  wire logic byte_rd = ar_r inside {`WD_OFF_RELOAD_UPPER, `WD_OFF_RELOAD_HIGH, `WD_OFF_RELOAD_LOW};
  wire logic stat_rd = s_axi_rvalid_o && ar_r == `WD_OFF_STATUS;
  // A new read cannot be taken while rvalid stands, so ar_r names the data shown
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ar_r <= '0;
      gap_r <= 16'h0000;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) ar_r <= s_axi_araddr_i;
      if (wd_reset_req_o) gap_r <= 16'h0000;
      else if (gap_r != 16'hffff) gap_r <= gap_r + 16'h0001;
    end
  end
  // Reload of at least four ticks puts a floor under the spacing of time-outs
  property p_pulse_gap;
    wd_reset_req_o |-> gap_r >= 16'(4 * TICK_DIV - 1);
  endproperty
  a_pulse_gap: assert property (p_pulse_gap) else $error("time-out too early");
  property p_pulse_one;
    wd_reset_req_o |=> !wd_reset_req_o [*3];
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("reset request not a pulse");
  property p_b_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_w_answer;
    // Both channels taken at one edge: the write lands one edge later, bvalid stands after that
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o;
  endproperty
  a_w_answer: assert property (p_w_answer) else $error("write answer late");
  property p_r_answer;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_byte_w;
    s_axi_rvalid_o && byte_rd |-> s_axi_rdata_o[31:8] == 24'h0;
  endproperty
  a_byte_w: assert property (p_byte_w) else $error("reload byte too wide");
  property p_lock_on;
    stat_rd && s_axi_rdata_o[1] |-> s_axi_rdata_o[0];
  endproperty
  a_lock_on: assert property (p_lock_on) else $error("locked while off");
  cover property (wd_reset_req_o);
  cover property (stat_rd && s_axi_rdata_o[1]);
  cover property (s_axi_bvalid_o && s_axi_bresp_o == `WD_RESP_SLVERR);
endmodule // watchdog_timeout_counter_checker

bind watchdog_timeout_counter watchdog_timeout_counter_checker #(.TICK_DIV(TICK_DIV)) chk_inst (
  .clk_i, .arst_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i, .wd_reset_req_o);

// >>> testbench/watchdog_timeout_counter_tb.sv
`timescale 1ns/1ps
`include "watchdog_defs.svh"
module watchdog_timeout_counter_tb;
  // Short tick keeps a reload of eight within 64 cycles
  localparam int unsigned TDIV = 8;
  logic clk_i = 1'b0, arst_n_i = 1'b0, opt = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rst_req, irq;
  logic [1:0] bresp, rresp, resp;
  int fails = 0, num_checks = 0, pulses = 0, n, k, p;
  watchdog_timeout_counter #(.TICK_DIV(TDIV)) watchdog_timeout_counter_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .watchdog_always_on_option_i(opt),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .wd_reset_req_o(rst_req), .irq_o(irq));
  initial forever #10 clk_i = ~clk_i;
  // Counted on the falling edge so the main sequence never races it
  always @(negedge clk_i) if (rst_req === 1'b1) pulses++;
  task give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task ran_out();
    fails++;
    $display("unexpected at %0t: wait ran out", $time);
    give_verdict();
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Answers are accepted one edge late so the slave must hold them
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1;
    end
    if (n == 40) ran_out();
    resp = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    if (n == 40) ran_out();
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task wait_pulse();
    for (n = 0; n < 100 && pulses == p; n++) @(posedge clk_i);
    if (pulses == p) ran_out();
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(`WD_OFF_STATUS);
    chk(d, 32'h0);
    rd(`WD_OFF_RELOAD_LOW);
    chk(d, 32'hff);
    rd(`WD_OFF_COUNT);
    chk(d, 32'hffffff);
    rd(8'h24);
    chk(resp, `WD_RESP_SLVERR);
    wr(8'h24, 32'h1);
    chk(resp, `WD_RESP_SLVERR);
    wr(`WD_OFF_RELOAD_UPPER, 32'h01);
    wr(`WD_OFF_RELOAD_HIGH, 32'h02);
    wr(`WD_OFF_RELOAD_LOW, 32'h03);
    wr(`WD_OFF_REFRESH, 32'h0);
    rd(`WD_OFF_STATUS);
    chk(d, 32'h1);
    rd(`WD_OFF_COUNT);
    chk(d >= 32'h010202 && d <= 32'h010203, 1);
    wr(`WD_OFF_RELOAD_UPPER, 32'h0);
    wr(`WD_OFF_RELOAD_HIGH, 32'h0);
    wr(`WD_OFF_RELOAD_LOW, 32'h08);
    wr(`WD_OFF_REFRESH, 32'h0);
    rd(`WD_OFF_COUNT);
    chk(d >= 32'h7 && d <= 32'h8, 1);
    repeat (6) begin
      repeat (20) @(posedge clk_i);
      wr(`WD_OFF_REFRESH, 32'h0);
    end
    chk(pulses, 0);
    p = pulses;
    wait_pulse();
    chk(n >= 50 && n <= 70, 1);
    p = pulses;
    wait_pulse();
    chk(n, 64);
    d = 32'h0;
    for (k = 0; k < 40 && d[1] !== 1'b1; k++) rd(`WD_OFF_STATUS);
    if (d[1] !== 1'b1) ran_out();
    p = pulses;
    wr(`WD_OFF_REFRESH, 32'h0);
    rd(`WD_OFF_INT_STAT);
    chk(d[1], 1'b1);
    wait_pulse();
    chk(n < 30, 1);
    wr(`WD_OFF_INT_STAT, 32'h3);
    wr(`WD_OFF_CTRL, 32'h1);
    wr(`WD_OFF_INT_MASK, 32'h1);
    p = pulses;
    for (n = 0; n < 100 && irq !== 1'b1; n++) @(posedge clk_i);
    if (irq !== 1'b1) ran_out();
    chk(irq, 1'b1);
    chk(pulses, p);
    rd(`WD_OFF_INT_STAT);
    chk(d[0], 1'b1);
    wr(`WD_OFF_INT_STAT, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    wr(`WD_OFF_INT_MASK, 32'h0);
    repeat (80) @(posedge clk_i);
    chk(irq, 1'b0);
    rd(`WD_OFF_INT_STAT);
    chk(d[0], 1'b1);
    arst_n_i <= 1'b0;
    opt <= 1'b1;
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd(`WD_OFF_STATUS);
    chk(d, 32'h5);
    give_verdict();
  end
endmodule // watchdog_timeout_counter_tb
